// [shared/sct_pkg.sv]
package sct_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // register offsets as printed
  localparam logic [7:0] SYNC_STARTUP_OFS   = 8'h38;
  localparam logic [7:0] SLOW_CLK_CTRL_OFS  = 8'h4B;
  localparam logic [7:0] FAST_CLK_TRIM_OFS  = 8'h4D;
  localparam logic [7:0] CONV_CLK_TIME_OFS  = 8'h4E;
  localparam logic [7:0] PIN_CFG_OFS        = 8'h4F;

  // reset values
  localparam logic [15:0] SYNC_STARTUP_RST  = 16'h0000;
  localparam logic [6:0]  SLOW_CTRL_RSV_RST = 7'h13;
  localparam logic [5:0]  SLOW_TRIM_RST     = 6'h12;
  localparam logic [7:0]  FAST_TRIM_RST     = 8'h98;
  localparam logic [15:0] CONV_CLK_TIME_RST = 16'h0060;
  localparam logic [15:0] PIN_CFG_RST       = 16'h2090;

  // value software loads for an external trigger source
  localparam logic [15:0] SYNC_STARTUP_EXT  = 16'h4000;

  // slow_clock_control fields
  localparam int unsigned SLOW_BYP_BIT      = 8;
  localparam int unsigned SLOW_ON_BIT       = 7;
  localparam int unsigned SLOW_TRIM_LSB     = 0;
  localparam int unsigned SLOW_TRIM_W       = 6;
  localparam int unsigned SLOW_RSV_LSB      = 9;

  // fast_clock_trim field
  localparam int unsigned FAST_TRIM_LSB     = 0;
  localparam int unsigned FAST_TRIM_W       = 8;

  // pin configuration fields
  localparam int unsigned PIN1_OE_BIT       = 6;
  localparam int unsigned PIN1_IE_BIT       = 5;
  localparam int unsigned TRIG_SEL_LSB      = 2;
  localparam int unsigned PIN0_IE_BIT       = 1;

  // trim code behaviour: slow code inverse, fast code direct
  localparam logic [5:0] SLOW_TRIM_FASTEST  = 6'h00;
  localparam logic [5:0] SLOW_TRIM_CENTRE   = 6'h22;
  localparam logic [5:0] SLOW_TRIM_SLOWEST  = 6'h3F;
  localparam logic [7:0] FAST_TRIM_SLOWEST  = 8'h00;
  localparam logic [7:0] FAST_TRIM_FASTEST  = 8'hFF;

  typedef enum logic [1:0] {
    SCT_TRIG_INTERNAL = 2'b00,
    SCT_TRIG_PIN0     = 2'b01,
    SCT_TRIG_PIN1     = 2'b10,
    SCT_TRIG_RESERVED = 2'b11
  } sct_trig_e;

  typedef struct packed {
    logic [5:0] slow_osc_trim;
    logic [7:0] fast_osc_trim;
  } sct_trim_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } sct_req_s;

endpackage

// [design/sct_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module sct_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // a zero-width synchroniser has nothing to carry
  if (WIDTH < 1) begin : g_width_check
    $error("sct_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second stage
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule // sct_sync
`default_nettype wire

// [design/sct_clock_trim.sv]
`timescale 1ns/1ps
`default_nettype none
module sct_clock_trim (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire sct_pkg::sct_req_s reg_req,
  output var  logic [15:0]     reg_rdata,
  output var  logic            reg_ack,
  input  wire logic            slow_osc_clk,
  input  wire logic            general_pin_0_in,
  input  wire logic            general_pin_1_in,
  output var  logic            general_pin_1_out,
  output var  logic            general_pin_1_oe,
  output var  sct_pkg::sct_trim_s trim_code,
  output var  logic            slow_osc_enable,
  output var  logic            sample_clk,
  output var  logic            sample_trigger
);
  import sct_pkg::*;

  logic [15:0] sync_startup_reg;
  logic [15:0] sync_startup_next;
  logic [6:0]  slow_rsv_reg;
  logic [6:0]  slow_rsv_next;
  logic        slow_osc_bypass_reg;
  logic        slow_osc_bypass_next;
  logic        sample_clock_on_reg;
  logic        sample_clock_on_next;
  logic        slow_bit6_reg;
  logic        slow_bit6_next;
  logic [5:0]  slow_osc_trim_reg;
  logic [5:0]  slow_osc_trim_next;
  logic [7:0]  fast_rsv_reg;
  logic [7:0]  fast_rsv_next;
  logic [7:0]  fast_osc_trim_reg;
  logic [7:0]  fast_osc_trim_next;
  logic [15:0] conv_time_reg;
  logic [15:0] conv_time_next;
  logic [15:0] pin_cfg_reg;
  logic [15:0] pin_cfg_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;

  logic [2:0]  pins_sync;
  logic        src_reg;
  logic        src_next;
  logic        prev_reg;
  logic        prev_next;
  logic        trig_reg;
  logic        trig_next;
  logic        pin0_prev_reg;
  logic        pin0_prev_next;
  logic        pin1_prev_reg;
  logic        pin1_prev_next;

  sct_trig_e   trig_sel;
  logic        pin1_ie;
  logic        pin0_ie;
  logic [15:0] slow_word;
  logic [15:0] fast_word;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // pin and oscillator levels come from outside this clock domain
  sct_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .async_in({slow_osc_clk, general_pin_1_in, general_pin_0_in}),
    .sync_out(pins_sync)
  );

  assign trig_sel = sct_trig_e'(pin_cfg_reg[TRIG_SEL_LSB +: 2]);
  assign pin1_ie  = pin_cfg_reg[PIN1_IE_BIT];
  assign pin0_ie  = pin_cfg_reg[PIN0_IE_BIT];
  assign slow_word = {slow_rsv_reg, slow_osc_bypass_reg, sample_clock_on_reg, slow_bit6_reg, slow_osc_trim_reg};
  assign fast_word = {fast_rsv_reg, fast_osc_trim_reg};

  // register file
  always_comb begin
    sync_startup_next    = sync_startup_reg;
    slow_rsv_next        = slow_rsv_reg;
    slow_osc_bypass_next = slow_osc_bypass_reg;
    sample_clock_on_next = sample_clock_on_reg;
    slow_bit6_next       = slow_bit6_reg;
    slow_osc_trim_next   = slow_osc_trim_reg;
    fast_rsv_next        = fast_rsv_reg;
    fast_osc_trim_next   = fast_osc_trim_reg;
    conv_time_next       = conv_time_reg;
    pin_cfg_next         = pin_cfg_reg;
    rdata_next           = rdata_reg;
    ack_next             = reg_req.wr | reg_req.rd;
    if (reg_req.wr) begin
      // the startup word is stored as written; matching it to the trigger source is software's job
      if (hit(reg_req.addr, SYNC_STARTUP_OFS)) begin
        sync_startup_next = reg_req.wdata;
      end
      if (hit(reg_req.addr, SLOW_CLK_CTRL_OFS)) begin
        slow_rsv_next        = reg_req.wdata[SLOW_RSV_LSB +: 7];
        slow_osc_bypass_next = reg_req.wdata[SLOW_BYP_BIT];
        sample_clock_on_next = reg_req.wdata[SLOW_ON_BIT];
        slow_bit6_next       = reg_req.wdata[SLOW_ON_BIT-1];
        slow_osc_trim_next   = reg_req.wdata[SLOW_TRIM_LSB +: SLOW_TRIM_W];
      end
      if (hit(reg_req.addr, FAST_CLK_TRIM_OFS)) begin
        fast_rsv_next      = reg_req.wdata[15:FAST_TRIM_W];
        fast_osc_trim_next = reg_req.wdata[FAST_TRIM_LSB +: FAST_TRIM_W];
      end
      if (hit(reg_req.addr, CONV_CLK_TIME_OFS)) begin
        conv_time_next = reg_req.wdata;
      end
      if (hit(reg_req.addr, PIN_CFG_OFS)) begin
        pin_cfg_next = reg_req.wdata;
      end
    end
    if (reg_req.rd) begin
      // unmapped offsets read as zero; a read in a write cycle returns the old value
      case (1'b1)
        hit(reg_req.addr, SYNC_STARTUP_OFS):  rdata_next = sync_startup_reg;
        hit(reg_req.addr, SLOW_CLK_CTRL_OFS): rdata_next = slow_word;
        hit(reg_req.addr, FAST_CLK_TRIM_OFS): rdata_next = fast_word;
        hit(reg_req.addr, CONV_CLK_TIME_OFS): rdata_next = conv_time_reg;
        hit(reg_req.addr, PIN_CFG_OFS):       rdata_next = pin_cfg_reg;
        default:                              rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_startup_reg    <= SYNC_STARTUP_RST;
      slow_rsv_reg        <= SLOW_CTRL_RSV_RST;
      slow_osc_bypass_reg <= 1'b0;
      sample_clock_on_reg <= 1'b0;
      slow_bit6_reg       <= 1'b0;
      slow_osc_trim_reg   <= SLOW_TRIM_RST;
      fast_rsv_reg        <= 8'h00;
      fast_osc_trim_reg   <= FAST_TRIM_RST;
      conv_time_reg       <= CONV_CLK_TIME_RST;
      pin_cfg_reg         <= PIN_CFG_RST;
      rdata_reg           <= 16'h0000;
      ack_reg             <= 1'b0;
    end else begin
      sync_startup_reg    <= sync_startup_next;
      slow_rsv_reg        <= slow_rsv_next;
      slow_osc_bypass_reg <= slow_osc_bypass_next;
      sample_clock_on_reg <= sample_clock_on_next;
      slow_bit6_reg       <= slow_bit6_next;
      slow_osc_trim_reg   <= slow_osc_trim_next;
      fast_rsv_reg        <= fast_rsv_next;
      fast_osc_trim_reg   <= fast_osc_trim_next;
      conv_time_reg       <= conv_time_next;
      pin_cfg_reg         <= pin_cfg_next;
      rdata_reg           <= rdata_next;
      ack_reg             <= ack_next;
    end
  end

  // sample clock path and trigger select
  always_comb begin
    // an external clock needs the pin input enabled, else the source reads low
    src_next = slow_osc_bypass_reg ? (pins_sync[1] & pin1_ie) : pins_sync[2];
    src_next = src_next & sample_clock_on_reg;
    prev_next      = src_reg;
    pin0_prev_next = pins_sync[0] & pin0_ie;
    pin1_prev_next = pins_sync[1] & pin1_ie;
    case (trig_sel)
      SCT_TRIG_INTERNAL: trig_next = src_reg & ~prev_reg;
      SCT_TRIG_PIN0:     trig_next = pins_sync[0] & pin0_ie & ~pin0_prev_reg;
      SCT_TRIG_PIN1:     trig_next = pins_sync[1] & pin1_ie & ~pin1_prev_reg;
      default:           trig_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      src_reg       <= 1'b0;
      prev_reg      <= 1'b0;
      pin0_prev_reg <= 1'b0;
      pin1_prev_reg <= 1'b0;
      trig_reg      <= 1'b0;
    end else begin
      src_reg       <= src_next;
      prev_reg      <= prev_next;
      pin0_prev_reg <= pin0_prev_next;
      pin1_prev_reg <= pin1_prev_next;
      trig_reg      <= trig_next;
    end
  end

  // codes pass straight to the oscillators; slow code is inverse, fast code direct in the analog cells
  assign trim_code.slow_osc_trim = slow_osc_trim_reg;
  assign trim_code.fast_osc_trim = fast_osc_trim_reg;
  // internal oscillator idles while bypassed to save power
  assign slow_osc_enable   = sample_clock_on_reg & ~slow_osc_bypass_reg;
  assign sample_clk        = src_reg;
  assign sample_trigger    = trig_reg;
  assign general_pin_1_out = 1'b0;
  assign general_pin_1_oe  = pin_cfg_reg[PIN1_OE_BIT];
  assign reg_rdata         = rdata_reg;
  assign reg_ack           = ack_reg;
endmodule // sct_clock_trim
`default_nettype wire

// [verification/sct_clock_trim_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module sct_clock_trim_chk (
  input wire logic               clk,
  input wire logic               rst,
  input wire sct_pkg::sct_req_s  reg_req,
  input wire logic [15:0]        reg_rdata,
  input wire logic               reg_ack,
  input wire logic               general_pin_1_oe,
  input wire sct_pkg::sct_trim_s trim_code,
  input wire logic               sample_trigger
);
  import sct_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_after_req: assert property (
    (reg_req.wr || reg_req.rd) |=> reg_ack) else $error("ack missing");
  a_ack_idle_low: assert property (
    !(reg_req.wr || reg_req.rd) |=> !reg_ack) else $error("stray ack");
  a_fast_trim_apply: assert property (
    reg_req.wr && reg_req.addr == FAST_CLK_TRIM_OFS |=> trim_code.fast_osc_trim == $past(reg_req.wdata[7:0]))
    else $error("fast trim not applied");
  a_slow_trim_apply: assert property (
    reg_req.wr && reg_req.addr == SLOW_CLK_CTRL_OFS |=> trim_code.slow_osc_trim == $past(reg_req.wdata[5:0]))
    else $error("slow trim not applied");
  a_trim_reset_value: assert property (
    $fell(rst) |-> trim_code == {SLOW_TRIM_RST, FAST_TRIM_RST}) else $error("trim reset wrong");
  a_oe_reset_low: assert property (
    $fell(rst) |-> !general_pin_1_oe) else $error("pin1 oe not reset");
  a_trig_one_cycle: assert property (
    sample_trigger |=> !sample_trigger) else $error("trigger too long");
  a_rdata_holds: assert property (
    !reg_req.rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule // sct_clock_trim_chk
bind sct_clock_trim sct_clock_trim_chk chk_u (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_ack(reg_ack), .general_pin_1_oe(general_pin_1_oe), .trim_code(trim_code), .sample_trigger(sample_trigger));
`default_nettype wire

// [verification/sct_clock_trim_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; $display("BAD t=%0t got %h want %h", $time, a, b); end end
module sct_clock_trim_bench;
  import sct_pkg::*;
  logic      clk = 1'b0, rst = 1'b1, slow_osc_clk = 1'b0, pin0 = 1'b0, pin1 = 1'b0, slow_run = 1'b0;
  sct_req_s  req = '0;
  logic [15:0] rdata;
  logic      ack, pin1_out, pin1_oe, slow_en, sample_clk, trig;
  sct_trim_s trim;
  int        failures = 0, samples_checked = 0, cycles = 0, n = 0;
  always #25 clk = ~clk;
  // slow oscillator stand-in: one period every four bench cycles, changing on falling edges only
  always #100 if (slow_run) slow_osc_clk = ~slow_osc_clk;
  sct_clock_trim dut_u (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .reg_ack(ack),
    .slow_osc_clk(slow_osc_clk), .general_pin_0_in(pin0), .general_pin_1_in(pin1),
    .general_pin_1_out(pin1_out), .general_pin_1_oe(pin1_oe), .trim_code(trim),
    .slow_osc_enable(slow_en), .sample_clk(sample_clk), .sample_trigger(trig));
  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  // one strobe cycle, then idle, so no signal is driven twice in a step
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    `CHK(ack, 1'b1)
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    `CHK(rdata, e)
  endtask
  task automatic watch(input int c);
    repeat (c) begin
      @(negedge clk);
      if (trig === 1'b1) n++;
    end
  endtask
  task automatic t_reset();
    rd_chk(SYNC_STARTUP_OFS, 16'h0000);
    rd_chk(SLOW_CLK_CTRL_OFS, 16'h2612);
    rd_chk(FAST_CLK_TRIM_OFS, 16'h0098);
    rd_chk(CONV_CLK_TIME_OFS, 16'h0060);
    rd_chk(PIN_CFG_OFS, 16'h2090);
    rd_chk(8'h40, 16'h0000);
    `CHK(trim, {6'h12, 8'h98})
    `CHK(pin1_oe, 1'b0)
    `CHK(slow_en, 1'b0)
    $display("test reset done");
  endtask
  task automatic t_trims();
    logic [5:0] s[3] = '{6'h00, 6'h22, 6'h3F};
    logic [7:0] f[3] = '{8'h00, 8'h98, 8'hFF};
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, SLOW_CLK_CTRL_OFS, {7'h13, 3'b000, s[i]});
      `CHK(trim.slow_osc_trim, s[i])
      acc(1'b1, FAST_CLK_TRIM_OFS, {8'h00, f[i]});
      `CHK(trim.fast_osc_trim, f[i])
      rd_chk(SLOW_CLK_CTRL_OFS, {7'h13, 3'b000, s[i]});
      rd_chk(FAST_CLK_TRIM_OFS, {8'h00, f[i]});
    end
    $display("test trims done");
  endtask
  task automatic t_startup();
    acc(1'b1, PIN_CFG_OFS, 16'h2094);
    acc(1'b1, SYNC_STARTUP_OFS, SYNC_STARTUP_EXT);
    rd_chk(SYNC_STARTUP_OFS, 16'h4000);
    acc(1'b1, PIN_CFG_OFS, 16'h2090);
    acc(1'b1, SYNC_STARTUP_OFS, 16'h0000);
    rd_chk(SYNC_STARTUP_OFS, 16'h0000);
    $display("test startup done");
  endtask
  task automatic t_gate();
    slow_run = 1'b1;
    acc(1'b1, SLOW_CLK_CTRL_OFS, 16'h2612);
    n = 0;
    watch(40);
    `CHK(n, 0)
    `CHK(sample_clk, 1'b0)
    acc(1'b1, SLOW_CLK_CTRL_OFS, 16'h2692);
    `CHK(slow_en, 1'b1)
    n = 0;
    watch(40);
    `CHK(n >= 9 && n <= 11, 1'b1)
    slow_run = 1'b0;
    $display("test gate done");
  endtask
  task automatic t_bypass();
    acc(1'b1, PIN_CFG_OFS, 16'h20B0);
    acc(1'b1, SLOW_CLK_CTRL_OFS, 16'h2792);
    `CHK(slow_en, 1'b0)
    `CHK(pin1_oe, 1'b0)
    for (int k = 0; k < 2; k++) begin
      watch(8);
      n = 0;
      repeat (5) begin
        pin1 = 1'b1;
        watch(3);
        `CHK(sample_clk, k == 0)
        pin1 = 1'b0;
        watch(3);
      end
      `CHK(n, k ? 0 : 5)
      acc(1'b1, PIN_CFG_OFS, 16'h2090);
    end
    acc(1'b1, PIN_CFG_OFS, 16'h20D0);
    `CHK(pin1_oe, 1'b1)
    `CHK(pin1_out, 1'b0)
    $display("test bypass done");
  endtask
  task automatic t_pin_trig();
    logic [15:0] cfg[4] = '{16'h2096, 16'h20B8, 16'h209E, 16'h2094};
    int          ex[4] = '{1, 1, 0, 0};
    acc(1'b1, SLOW_CLK_CTRL_OFS, 16'h2612);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, PIN_CFG_OFS, cfg[i]);
      watch(4);
      n = 0;
      pin0 = 1'b1;
      pin1 = 1'b1;
      watch(6);
      pin0 = 1'b0;
      pin1 = 1'b0;
      watch(6);
      `CHK(n, ex[i])
    end
    $display("test pin trigger done");
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_trims();
    t_startup();
    t_gate();
    t_bypass();
    t_pin_trig();
    // reset again in mid-run: the fast trim was left at its extreme code 8'hFF, so the reset values must return
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_reset();
    final_report();
  end
endmodule // sct_clock_trim_bench
`default_nettype wire
